// File: teu_consts.svh
// constants for the trap exception unit
`ifndef TEU_CONSTS_SVH
`define TEU_CONSTS_SVH
`define TEU_TRAP_VECTOR 32'h0fff_ff00
`define TEU_CORE_HALF_OFS 32'h0000_0004
`define TEU_LOCK_WINDOW 6'h20
`define TEU_REG_CTRL 32'h0000_0000
`define TEU_REG_STATUS 32'h0000_0004
`define TEU_REG_FIR 32'h0000_0008
`define TEU_REG_FSR 32'h0000_000c
`define TEU_REG_RESTART 32'h0000_0010
`define TEU_CTRL_USER 0
`define TEU_CTRL_IRQEN 1
`define TEU_CTRL_RDWATCH 2
`define TEU_CTRL_WRWATCH 3
`define TEU_CTRL_PGSIZE 4
`define TEU_CTRL_BUSLOCK 5
`define TEU_CTRL_XLATE 6
`define TEU_CTRL_FTE 7
`define TEU_CTRL_FZ 8
`define TEU_CTRL_TI 9
`define TEU_FSR_ADD_LO 22
`define TEU_FSR_MUL_LO 9
`define TEU_FSR_RR_LO 17
`endif

// File: teu_pkg.sv
// types for the trap exception unit
package teu_pkg;
	typedef struct packed {
		logic sw;
		logic irq;
		logic fetch;
		logic operand;
		logic flt;
	} teu_cause_t;
	typedef struct packed {
		logic user;
		logic irq_en;
		logic saved_priv;
		logic saved_irq;
		logic paired;
		logic switch_pend;
		logic lock_to;
		logic op_exc;
		logic byte_code;
		logic rd_watch;
		logic wr_watch;
		logic pg_size;
		logic bus_lock;
		logic xlate;
		logic float_trap_enable;
		logic fz;
		logic ti;
	} teu_flags_t;
	typedef enum logic [1:0] {TEU_RUN, TEU_ENTER, TEU_HALT} teu_state_t;
	typedef struct packed {
		teu_state_t st;
		teu_flags_t f;
		teu_cause_t cause;
		logic [31:0] fir;
		logic [7:0] add_stat;
		logic [7:0] mul_stat;
		logic [4:0] rr;
		logic [5:0] lock_cnt;
		logic lock_act;
		logic [1:0] irq_sync;
		logic rst_seen;
		logic redirect;
		logic abort;
		logic half_commit;
		logic hold_pipe;
		logic flush_icache;
		logic single_mode;
		logic hready;
		logic [31:0] hrdata;
		logic [31:0] addr;
		logic wr;
		logic sel;
	} teu_state_s_t;
endpackage

// File: teu_trap_unit.sv
// trap detection, state save and fetch redirection with an ahb-lite register slave
//
// What this block does
// - any non-reset trap aborts the current instruction, leaving it restartable
// - on entry copy privilege and interrupt enable into their saved flags
// - on entry clear privilege to supervisor and clear interrupt enable
// - on entry record whether trapped while in paired issue
// - on entry record whether a single/dual issue switch was due
// - set every cause bit present; several may be set at once
// - fault address is instruction, or float half in dual; core half is plus 4
// - dual-mode lone operand fault: float half already completed, except float-to-integer transfer
// - after entry fetch handler at the fixed vector in single mode
// - trap instruction, and overflow-trap with sticky overflow, raise software trap
// - no unlock within 32 instructions of lock raises software trap plus timeout flag
// - exceptional float operand raises float fault, sets operand flag, pipeline holds
// - result exceptions: overflow, underflow unless flush, inexact only if enabled
// - scalar result exception reported on next float or store instruction
// - pipelined result exception reported at last stage; pipeline then holds
// - no trap when float traps disabled or clean: pipeline advances normally
// - status fields 29..22 and 16..9 show last-stage adder and multiplier status
// - result index set by scalar initiation, cleared by pipelined initiation
// - page-not-present on fetch raises fetch fault with its cause bit
// - data fault for dirty-clear write, misalign, watch hit, not present, protection
// - external interrupt with interrupts enabled sets its cause and traps
// - reset: vector, single mode, no causes, control bits cleared, code mode latched
//
// Local design decisions: the address map and register access over AHB-Lite.
`timescale 1ns/1ns
`include "teu_consts.svh"
module teu_trap_unit
	import teu_pkg::*;
(
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic hresp,
	output logic [31:0] hrdata,
	input wire logic irq_pin,
	input wire logic instr_valid,
	input wire logic [31:0] instr_addr,
	input wire logic dual_mode,
	input wire logic mode_switch_due,
	input wire logic trap_instr,
	input wire logic ovf_trap_instr,
	input wire logic overflow_sticky,
	input wire logic lock_instr,
	input wire logic unlock_instr,
	input wire logic fp_instr,
	input wire logic fp_store_instr,
	input wire logic fp_scalar_init,
	input wire logic fp_pipe_init,
	input wire logic [4:0] fp_dest,
	input wire logic float_xfer_instr,
	input wire logic src_exc_operand,
	input wire logic add_last_ovf,
	input wire logic add_last_unf,
	input wire logic add_last_inx,
	input wire logic mul_last_ovf,
	input wire logic mul_last_unf,
	input wire logic mul_last_inx,
	input wire logic [7:0] add_last_stat,
	input wire logic [7:0] mul_last_stat,
	input wire logic fetch_not_present,
	input wire logic data_dirty_clear_wr,
	input wire logic data_misaligned,
	input wire logic data_watch_hit,
	input wire logic data_not_present,
	input wire logic data_protect,
	output logic trap_abort,
	output logic fp_pipe_hold,
	output logic fp_half_commit,
	output logic fetch_redirect,
	output logic [31:0] fetch_vector,
	output logic single_issue_force,
	output logic icache_flush,
	output logic [31:0] core_half_addr
);
	teu_state_s_t s_r, s_nxt;
	logic irq_live, res_exc, report_pt, lock_exp, data_fault, any_trap;
	teu_cause_t cz;

	// ==========================================
	// trap detection
	always_comb begin
		irq_live = s_r.irq_sync[1];
		res_exc = add_last_ovf | mul_last_ovf
			| ((add_last_unf | mul_last_unf) & ~s_r.f.fz)
			| ((add_last_inx | mul_last_inx) & s_r.f.ti);
		// reporting happens only when the next float or store instruction arrives
		report_pt = instr_valid & (fp_instr | fp_store_instr);
		lock_exp = s_r.lock_act & (s_r.lock_cnt == `TEU_LOCK_WINDOW) & ~unlock_instr;
		data_fault = data_dirty_clear_wr | data_misaligned | data_watch_hit
			| data_not_present | data_protect;
		cz.sw = instr_valid & (trap_instr | (ovf_trap_instr & overflow_sticky)) | lock_exp;
		cz.irq = irq_live & s_r.f.irq_en;
		cz.fetch = fetch_not_present;
		cz.operand = instr_valid & data_fault;
		cz.flt = s_r.f.float_trap_enable & ((instr_valid & src_exc_operand) | (report_pt & res_exc));
		any_trap = |cz;
	end

	// ==========================================
	// state update
	always_comb begin
		s_nxt = s_r;
		s_nxt.irq_sync = {s_r.irq_sync[0], irq_pin};
		s_nxt.redirect = 1'b0;
		s_nxt.abort = 1'b0;
		s_nxt.half_commit = 1'b0;
		s_nxt.hold_pipe = 1'b0;
		s_nxt.flush_icache = 1'b0;
		// reset entry: catch code width strap on the first edge after release
		if (!s_r.rst_seen) begin
			s_nxt.rst_seen = 1'b1;
			s_nxt.f.byte_code = irq_pin;
			s_nxt.redirect = 1'b1;
			s_nxt.flush_icache = 1'b1;
			s_nxt.single_mode = 1'b1;
		end else begin
			if (instr_valid) begin
				if (lock_instr) begin
					s_nxt.lock_act = 1'b1;
					s_nxt.lock_cnt = 6'h00;
				end else if (unlock_instr) begin
					s_nxt.lock_act = 1'b0;
				end else if (s_r.lock_act && s_r.lock_cnt != `TEU_LOCK_WINDOW) begin
					s_nxt.lock_cnt = s_r.lock_cnt + 6'h01;
				end
				if (!any_trap) begin
					if (fp_scalar_init) s_nxt.rr = fp_dest;
					else if (fp_pipe_init) s_nxt.rr = 5'h00;
				end
			end
			if (instr_valid && !any_trap) s_nxt.single_mode = ~dual_mode;
			if (any_trap) begin
				s_nxt.abort = 1'b1;
				s_nxt.f.saved_priv = s_r.f.user;
				s_nxt.f.saved_irq = s_r.f.irq_en;
				s_nxt.f.user = 1'b0;
				s_nxt.f.irq_en = 1'b0;
				s_nxt.f.paired = dual_mode;
				s_nxt.f.switch_pend = mode_switch_due;
				s_nxt.cause = cz;
				s_nxt.fir = instr_addr;
				s_nxt.redirect = 1'b1;
				s_nxt.single_mode = 1'b1;
				// the float half has retired only when the data fault stands alone
				// and the float half is not a transfer into the core registers
				s_nxt.half_commit = dual_mode & ~float_xfer_instr
					& (cz == teu_cause_t'(5'h02));
				if (lock_exp) begin
					s_nxt.f.lock_to = 1'b1;
					s_nxt.lock_act = 1'b0;
				end
				if (cz.flt) begin
					s_nxt.hold_pipe = 1'b1;
					if (src_exc_operand) s_nxt.f.op_exc = 1'b1;
				end
				if (report_pt) begin
					s_nxt.add_stat = add_last_stat;
					s_nxt.mul_stat = mul_last_stat;
				end
			end
		end
		// ==========================================
		// ahb-lite slave, zero wait states
		s_nxt.hready = 1'b1;
		if (s_r.sel && s_r.wr) begin
			unique case (s_r.addr)
				`TEU_REG_CTRL: begin
					if (!any_trap) begin
						s_nxt.f.user = hwdata[`TEU_CTRL_USER];
						s_nxt.f.irq_en = hwdata[`TEU_CTRL_IRQEN];
					end
					s_nxt.f.rd_watch = hwdata[`TEU_CTRL_RDWATCH];
					s_nxt.f.wr_watch = hwdata[`TEU_CTRL_WRWATCH];
					s_nxt.f.pg_size = hwdata[`TEU_CTRL_PGSIZE];
					s_nxt.f.bus_lock = hwdata[`TEU_CTRL_BUSLOCK];
					s_nxt.f.xlate = hwdata[`TEU_CTRL_XLATE];
					s_nxt.f.float_trap_enable = hwdata[`TEU_CTRL_FTE];
					s_nxt.f.fz = hwdata[`TEU_CTRL_FZ];
					s_nxt.f.ti = hwdata[`TEU_CTRL_TI];
				end
				// writing status clears flags by writing one; a fresh trap wins
				`TEU_REG_STATUS: if (!any_trap) begin
					s_nxt.cause = s_r.cause & ~teu_cause_t'(hwdata[4:0]);
					s_nxt.f.lock_to = s_r.f.lock_to & ~hwdata[5];
					s_nxt.f.op_exc = s_r.f.op_exc & ~hwdata[6];
				end
				default: ;
			endcase
		end
		s_nxt.sel = hsel & htrans[1] & hready;
		s_nxt.wr = hwrite;
		s_nxt.addr = haddr;
		s_nxt.hrdata = 32'h0000_0000;
		if (hsel && htrans[1] && hready && !hwrite) begin
			unique case (haddr)
				`TEU_REG_CTRL: s_nxt.hrdata = {22'h000000, s_r.f.ti, s_r.f.fz, s_r.f.float_trap_enable,
					s_r.f.xlate, s_r.f.bus_lock, s_r.f.pg_size, s_r.f.wr_watch,
					s_r.f.rd_watch, s_r.f.irq_en, s_r.f.user};
				`TEU_REG_STATUS: s_nxt.hrdata = {20'h00000, s_r.f.byte_code, s_r.f.switch_pend,
					s_r.f.paired, s_r.f.saved_irq, s_r.f.saved_priv, s_r.f.op_exc,
					s_r.f.lock_to, s_r.cause};
				`TEU_REG_FIR: s_nxt.hrdata = s_r.fir;
				`TEU_REG_FSR: s_nxt.hrdata = {2'h0, s_r.add_stat, s_r.rr, s_r.mul_stat, 9'h000};
				default: s_nxt.hrdata = 32'h0000_0000;
			endcase
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			s_r <= '0;
		end else begin
			s_r <= s_nxt;
		end
	end

	// ==========================================
	// outputs
	assign hreadyout = 1'b1;
	assign hresp = 1'b0;
	assign hrdata = s_r.hrdata;
	assign trap_abort = s_r.abort;
	assign fp_pipe_hold = s_r.hold_pipe;
	// float half done only for a lone operand fault in dual mode, not a transfer
	assign fp_half_commit = s_r.half_commit;
	assign fetch_redirect = s_r.redirect;
	assign fetch_vector = `TEU_TRAP_VECTOR;
	assign single_issue_force = s_r.single_mode;
	assign icache_flush = s_r.flush_icache;
	assign core_half_addr = s_r.fir + `TEU_CORE_HALF_OFS;

	// ==========================================
	// checks
	// entry is split into its steps: a cause seen, then the pulses one cycle on
	sequence seq_trap_in;
		s_r.rst_seen && any_trap;
	endsequence
	sequence seq_entered;
		fetch_redirect && single_issue_force && trap_abort;
	endsequence
	sequence seq_float_issue;
		s_r.rst_seen && s_r.f.float_trap_enable && instr_valid;
	endsequence

	AST_ENTRY: assert property (@(posedge hclk) disable iff (!hresetn)
		seq_trap_in |=> seq_entered)
		else $error("trap entry not taken");
	AST_SINGLE: assert property (@(posedge hclk) disable iff (!hresetn)
		fetch_redirect
		|-> single_issue_force && fetch_vector == `TEU_TRAP_VECTOR)
		else $error("redirect not to vector in single mode");
	AST_ABORT: assert property (@(posedge hclk) disable iff (!hresetn)
		s_r.rst_seen && !any_trap
		|=> !trap_abort)
		else $error("abort without a trap");
	AST_SAVE: assert property (@(posedge hclk) disable iff (!hresetn)
		seq_trap_in |=> s_r.f.saved_irq == $past(s_r.f.irq_en)
		&& s_r.f.saved_priv == $past(s_r.f.user))
		else $error("state not saved");
	AST_SUPER: assert property (@(posedge hclk) disable iff (!hresetn)
		seq_trap_in
		|=> !s_r.f.user && !s_r.f.irq_en)
		else $error("not supervisor");
	AST_PAIRED: assert property (@(posedge hclk) disable iff (!hresetn)
		seq_trap_in
		|=> s_r.f.paired == $past(dual_mode))
		else $error("paired flag");
	AST_SWPEND: assert property (@(posedge hclk) disable iff (!hresetn)
		seq_trap_in
		|=> s_r.f.switch_pend == $past(mode_switch_due))
		else $error("switch pending flag");
	AST_MULTI: assert property (@(posedge hclk) disable iff (!hresetn)
		seq_trap_in ##0 (instr_valid && trap_instr && data_misaligned)
		|=> s_r.cause.sw && s_r.cause.operand)
		else $error("coinciding causes not all set");
	AST_FIR: assert property (@(posedge hclk) disable iff (!hresetn)
		seq_trap_in
		|=> core_half_addr == $past(instr_addr) + 32'h4)
		else $error("core half address");
	AST_FIR_REG: assert property (@(posedge hclk) disable iff (!hresetn)
		seq_trap_in
		|=> s_r.fir == $past(instr_addr))
		else $error("fault address");
	AST_HALF_ON: assert property (@(posedge hclk) disable iff (!hresetn)
		seq_trap_in ##0 (dual_mode && !float_xfer_instr && cz == teu_cause_t'(5'h02))
		|=> fp_half_commit)
		else $error("float half not committed");
	AST_HALF_XFER: assert property (@(posedge hclk) disable iff (!hresetn)
		seq_trap_in ##0 float_xfer_instr
		|=> !fp_half_commit)
		else $error("transfer half committed");
	AST_SWTRAP: assert property (@(posedge hclk) disable iff (!hresetn)
		s_r.rst_seen && instr_valid && ovf_trap_instr && overflow_sticky
		|=> s_r.cause.sw)
		else $error("overflow trap missed");
	AST_TRAPINSTR: assert property (@(posedge hclk) disable iff (!hresetn)
		s_r.rst_seen && instr_valid && trap_instr
		|=> trap_abort && s_r.cause.sw)
		else $error("trap instruction missed");
	AST_LOCK: assert property (@(posedge hclk) disable iff (!hresetn)
		s_r.rst_seen && s_r.lock_act && s_r.lock_cnt == `TEU_LOCK_WINDOW && !unlock_instr
		|=> s_r.f.lock_to && s_r.cause.sw)
		else $error("lock timeout missed");
	AST_OPEXC: assert property (@(posedge hclk) disable iff (!hresetn)
		seq_float_issue ##0 src_exc_operand
		|=> s_r.f.op_exc && fp_pipe_hold && s_r.cause.flt)
		else $error("operand exception missed");
	AST_RES_OVF: assert property (@(posedge hclk) disable iff (!hresetn)
		seq_float_issue ##0 (fp_instr && (add_last_ovf || mul_last_ovf))
		|=> s_r.cause.flt && fp_pipe_hold)
		else $error("overflow not reported");
	AST_RES_FZ: assert property (@(posedge hclk) disable iff (!hresetn)
		seq_float_issue ##0 (s_r.f.fz && !src_exc_operand && !add_last_ovf && !mul_last_ovf
		&& !add_last_inx && !mul_last_inx)
		|=> !fp_pipe_hold)
		else $error("underflow trapped while flushing");
	AST_STORE_RPT: assert property (@(posedge hclk) disable iff (!hresetn)
		seq_float_issue ##0 (fp_store_instr && add_last_ovf)
		|=> s_r.cause.flt)
		else $error("result exception not on store");
	AST_NO_RPT: assert property (@(posedge hclk) disable iff (!hresetn)
		s_r.rst_seen && !(instr_valid && (fp_instr || fp_store_instr || src_exc_operand))
		|=> !fp_pipe_hold)
		else $error("float trap off a reporting point");
	AST_FTE_OFF: assert property (@(posedge hclk) disable iff (!hresetn)
		!s_r.f.float_trap_enable
		|-> !cz.flt)
		else $error("float trap while disabled");
	AST_FTE_HOLD: assert property (@(posedge hclk) disable iff (!hresetn)
		s_r.rst_seen && !s_r.f.float_trap_enable
		|=> !fp_pipe_hold)
		else $error("pipeline held while float traps off");
	AST_STAT: assert property (@(posedge hclk) disable iff (!hresetn)
		seq_trap_in ##0 report_pt
		|=> s_r.add_stat == $past(add_last_stat) && s_r.mul_stat == $past(mul_last_stat))
		else $error("last-stage status not captured");
	AST_RR_SCALAR: assert property (@(posedge hclk) disable iff (!hresetn)
		s_r.rst_seen && instr_valid && fp_scalar_init && !any_trap
		|=> s_r.rr == $past(fp_dest))
		else $error("result index not written");
	AST_RR_PIPE: assert property (@(posedge hclk) disable iff (!hresetn)
		s_r.rst_seen && instr_valid && fp_pipe_init && !fp_scalar_init && !any_trap
		|=> s_r.rr == 5'h00)
		else $error("result index not cleared");
	AST_FETCH: assert property (@(posedge hclk) disable iff (!hresetn)
		s_r.rst_seen && fetch_not_present
		|=> trap_abort && s_r.cause.fetch)
		else $error("fetch fault missed");
	AST_OPFAULT: assert property (@(posedge hclk) disable iff (!hresetn)
		s_r.rst_seen && instr_valid && (data_dirty_clear_wr || data_misaligned
		|| data_watch_hit || data_not_present || data_protect)
		|=> trap_abort && s_r.cause.operand)
		else $error("data fault missed");
	AST_IRQ: assert property (@(posedge hclk) disable iff (!hresetn)
		s_r.rst_seen && s_r.f.irq_en && s_r.irq_sync[1]
		|=> s_r.cause.irq)
		else $error("irq missed");
	AST_IRQ_OFF: assert property (@(posedge hclk) disable iff (!hresetn)
		s_r.rst_seen && !s_r.f.irq_en
		|=> !(trap_abort && s_r.cause.irq))
		else $error("irq taken while disabled");
	AST_RESET_ENTRY: assert property (@(posedge hclk) disable iff (!hresetn)
		!s_r.rst_seen
		|=> fetch_redirect && icache_flush && single_issue_force && s_r.cause == '0)
		else $error("reset entry");
	AST_RESET_CTRL: assert property (@(posedge hclk) disable iff (!hresetn)
		!s_r.rst_seen
		|-> !s_r.f.user && !s_r.f.irq_en && !s_r.f.rd_watch && !s_r.f.wr_watch
		&& !s_r.f.pg_size && !s_r.f.bus_lock && !s_r.f.xlate)
		else $error("control bits not cleared by reset");
	AST_SYNC: assert property (@(posedge hclk) disable iff (!hresetn)
		s_r.rst_seen && irq_pin ##1 irq_pin
		|=> s_r.irq_sync[1])
		else $error("sync");
endmodule

// File: tb_teu_trap_unit.sv
// self-checking bench for the trap exception unit
`timescale 1ns/1ns
`include "teu_consts.svh"
module tb_teu_trap_unit;
	logic hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0, irq_pin = 1'b1;
	logic instr_valid = 1'b0, dual_mode = 1'b0, mode_switch_due = 1'b0, overflow_sticky = 1'b0;
	logic hreadyout, hresp, trap_abort, fp_pipe_hold, fetch_redirect, single_issue_force;
	logic icache_flush, fp_half_commit;
	logic [1:0] htrans = 2'h0;
	logic [4:0] fp_dest = 5'h0;
	logic [7:0] add_st = 8'h5a, mul_st = 8'ha5;
	logic [21:0] ev = 22'h0;
	logic [31:0] haddr = 32'h0, hwdata = 32'h0, instr_addr = 32'h0, q, c;
	logic [31:0] hrdata, fetch_vector, core_half_addr;
	// per row: control word, one-cycle events, expected status (zero when no trap may follow)
	logic [9:0] tc [15] = '{10'h0, 10'h0, 10'h0, 10'h0, 10'h0, 10'h0, 10'h0, 10'h80, 10'h80,
		10'h180, 10'h80, 10'h80, 10'h280, 10'h0, 10'h80};
	logic [21:0] te [15] = '{22'h101, 22'h80, 22'h100, 22'h200, 22'h400, 22'h800, 22'h40,
		22'h30, 22'h4010, 22'h8010, 22'h8010, 22'h10010, 22'h10010, 22'h4010, 22'ha0000};
	logic [11:0] ts [15] = '{12'h812, 12'h802, 12'h802, 12'h802, 12'h802, 12'h802, 12'h804,
		12'h841, 12'h801, 12'h0, 12'h801, 12'h0, 12'h801, 12'h0, 12'h801};
	int n_errors = 0, total_checks = 0;

	teu_trap_unit i_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
		.hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .irq_pin(irq_pin),
		.instr_valid(instr_valid), .instr_addr(instr_addr), .dual_mode(dual_mode),
		.mode_switch_due(mode_switch_due), .trap_instr(ev[0]), .ovf_trap_instr(ev[1]),
		.overflow_sticky(overflow_sticky), .lock_instr(ev[2]), .unlock_instr(ev[3]),
		.fp_instr(ev[4]), .fp_store_instr(ev[17]), .fp_scalar_init(ev[12]),
		.fp_pipe_init(ev[13]), .fp_dest(fp_dest), .float_xfer_instr(ev[18]),
		.src_exc_operand(ev[5]), .add_last_ovf(ev[19]), .add_last_unf(ev[15]),
		.add_last_inx(ev[16]), .mul_last_ovf(ev[14]), .mul_last_unf(ev[20]),
		.mul_last_inx(ev[21]), .add_last_stat(add_st), .mul_last_stat(mul_st),
		.fetch_not_present(ev[6]), .data_dirty_clear_wr(ev[7]), .data_misaligned(ev[8]),
		.data_watch_hit(ev[9]), .data_not_present(ev[10]), .data_protect(ev[11]),
		.trap_abort(trap_abort), .fp_pipe_hold(fp_pipe_hold), .fp_half_commit(fp_half_commit),
		.fetch_redirect(fetch_redirect), .fetch_vector(fetch_vector),
		.single_issue_force(single_issue_force), .icache_flush(icache_flush),
		.core_half_addr(core_half_addr));

	initial begin
		forever #2 hclk = ~hclk;
	end

	// ==========================================================
	// helpers
	task automatic results();
		$display("checks %0d errors %0d", total_checks, n_errors);
		if (n_errors == 0 && total_checks > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		total_checks++;
		if (g !== e) begin
			n_errors++;
			$display("ERROR t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask
	// bounded so a stuck slave ends the run instead of hanging it
	task automatic wait_rdy();
		int k;
		k = 0;
		do begin
			@(posedge hclk);
			k++;
		end while (hreadyout !== 1'b1 && k < 50);
		if (k >= 50) begin
			n_errors++;
			results();
		end
	endtask
	task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] d);
		@(posedge hclk);
		hsel <= 1'b1;
		htrans <= 2'h2;
		haddr <= a;
		hwrite <= w;
		wait_rdy();
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		wait_rdy();
		q = hrdata;
	endtask
	// one instruction cycle of events; abort and redirect show in the cycle after
	task automatic fire(input logic [21:0] e, input logic x);
		@(posedge hclk);
		ev <= e;
		instr_valid <= 1'b1;
		@(posedge hclk);
		ev <= 22'h0;
		instr_valid <= 1'b0;
		#1 chk({30'h0, trap_abort, fetch_redirect}, {30'h0, x, x});
	endtask
	// status is read, judged, then its cause and fault flags are cleared for the next case
	task automatic st(input logic [31:0] e);
		bus(1'b0, `TEU_REG_STATUS, 32'h0);
		chk(q & 32'hfff, e);
		bus(1'b1, `TEU_REG_STATUS, 32'h7f);
	endtask

	// ==========================================================
	// scenarios
	task automatic t_reset();
		@(posedge hclk);
		#1 chk({29'h0, fetch_redirect, icache_flush, single_issue_force}, 32'h7);
		chk(fetch_vector, 32'h0ffff_f00);
		@(posedge hclk);
		irq_pin <= 1'b0;
		bus(1'b0, `TEU_REG_CTRL, 32'h0);
		chk(q & 32'h3ff, 32'h0);
		st(32'h800);
	endtask
	task automatic t_entry();
		bus(1'b1, `TEU_REG_CTRL, 32'h3);
		dual_mode <= 1'b1;
		mode_switch_due <= 1'b1;
		instr_addr <= 32'h0000_1230;
		fire(22'h1, 1'b1);
		bus(1'b0, `TEU_REG_CTRL, 32'h0);
		chk(q & 32'h3, 32'h0);
		bus(1'b0, `TEU_REG_FIR, 32'h0);
		chk(q, 32'h0000_1230);
		chk(core_half_addr, 32'h0000_1234);
		st(32'hf90);
		dual_mode <= 1'b0;
		mode_switch_due <= 1'b0;
		fire(22'h2, 1'b0);
		overflow_sticky <= 1'b1;
		fire(22'h2, 1'b1);
		st(32'h810);
	endtask
	task automatic t_lock(input logic unl);
		fire(22'h4, 1'b0);
		if (unl) begin
			fire(22'h8, 1'b0);
		end
		c = 32'h0;
		instr_valid <= 1'b1;
		repeat (30) begin
			@(posedge hclk);
			#1 c = c + trap_abort;
		end
		chk(c, 32'h0);
		repeat (8) begin
			@(posedge hclk);
			#1 c = c + trap_abort;
		end
		chk(c, {31'h0, !unl});
		@(posedge hclk);
		instr_valid <= 1'b0;
		if (!unl) begin
			st(32'h830);
		end
	endtask
	task automatic t_irq();
		@(posedge hclk);
		irq_pin <= 1'b1;
		c = 32'h0;
		repeat (8) begin
			@(posedge hclk);
			#1 c = c + trap_abort;
		end
		bus(1'b1, `TEU_REG_CTRL, 32'h2);
		repeat (10) begin
			@(posedge hclk);
			#1 c = c + trap_abort;
		end
		chk(c, 32'h1);
		@(posedge hclk);
		irq_pin <= 1'b0;
		st(32'h908);
	endtask
	task automatic t_table();
		for (int i = 0; i < 15; i++) begin
			bus(1'b1, `TEU_REG_CTRL, {22'h0, tc[i]});
			fire(te[i], ts[i] != 12'h0);
			if (i > 6 && i < 14) begin
				chk({31'h0, fp_pipe_hold}, {31'h0, ts[i] != 12'h0});
			end
			if (ts[i] != 12'h0) begin
				st({20'h0, ts[i]});
			end
		end
	endtask
	task automatic t_fsr();
		fp_dest <= 5'h13;
		fire(22'h1000, 1'b0);
		bus(1'b0, `TEU_REG_FSR, 32'h0);
		chk(q & 32'h3ffffe00, 32'h16a74a00);
		fire(22'h2000, 1'b0);
		bus(1'b0, `TEU_REG_FSR, 32'h0);
		chk(q & 32'h3ffffe00, 32'h16814a00);
	endtask
	// lone data fault in dual mode: float half retired unless it is a transfer
	task automatic t_half();
		dual_mode <= 1'b1;
		fire(22'h100, 1'b1);
		chk({31'h0, fp_half_commit}, 32'h1);
		st(32'ha02);
		fire(22'h40100, 1'b1);
		chk({31'h0, fp_half_commit}, 32'h0);
		st(32'ha02);
		dual_mode <= 1'b0;
	endtask

	initial begin
		repeat (2) @(posedge hclk);
		hresetn <= 1'b1;
		t_reset();
		t_entry();
		t_lock(1'b1);
		t_lock(1'b0);
		t_irq();
		t_table();
		t_fsr();
		t_half();
		results();
	end
endmodule
